// ---- hw/reg_store.sv ----
// register store with registered read data
`timescale 1ns/1ps
module reg_store
   import serial_access_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // write side
   input  wire reg_write_t  wr,
   // read side
   input  wire logic [7:0]  rd_addr,
   output logic      [15:0] rd_data
);
   logic [15:0] mem [REG_COUNT];
   logic [15:0] next_rd_data;

   // read data leaves through a flop, one cycle after the address
   always_comb
   begin
      next_rd_data = mem[rd_addr];
   end

   // contents are not reset; only the read register is
   always_ff @(posedge clk)
   begin
      if (wr.en)
      begin
         mem[wr.addr] <= wr.data;
      end
      if (!rst_b)
      begin
         rd_data <= REG_RESET_VAL;
      end
      else
      begin
         rd_data <= next_rd_data;
      end
   end
endmodule // reg_store

// ---- hw/serial_access_pkg.sv ----
// constants and carrier types for the serial register access port
package serial_access_pkg;
   localparam int unsigned ADDR_BITS      = 8;
   localparam int unsigned DATA_BITS      = 16;
   localparam int unsigned WORD_BITS      = ADDR_BITS + DATA_BITS;
   localparam int unsigned REG_COUNT      = 256;
   localparam logic [4:0]  BIT_COUNT_LAST = 5'h17;
   localparam logic [4:0]  BIT_COUNT_ZERO = 5'h00;
   localparam logic [7:0]  READ_MODE_ADDR = 8'h00;
   localparam int unsigned READ_MODE_BIT  = 1;
   localparam logic [15:0] REG_RESET_VAL  = 16'h0000;

   // one committed word, address then data
   typedef struct packed {
      logic [7:0]  addr;
      logic [15:0] data;
   } serial_word_t;

   // write port of the register store
   typedef struct packed {
      logic        en;
      logic [7:0]  addr;
      logic [15:0] data;
   } reg_write_t;
endpackage

// ---- hw/serial_register_access_port.sv ----
// serial register access port: shift-in, commit, readback shift-out
//
// Function
// R1: shift only while select held low
// R2: sample input on shift clock rising edge
// R3: commit word on every 24th edge
// R4: drop trailing partial word on select rise
// R5: several words per select, counter restarts each
// R6: word is 8 address then 16 data
// R7: controller sets readback bit, then sends address
// R8: readback drives addressed register, ignores data
// R9: controller samples output rising or falling edge
// R10: readback blocks writes except readback bit
// R11: output driver enabled only in readback mode
// R12: msb first, readback aligned to data field
`timescale 1ns/1ps
module serial_register_access_port
   import serial_access_pkg::*;
(
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_b,
   // serial pins from the controller
   input  wire logic serial_select_n,
   input  wire logic serial_clk,
   input  wire logic serial_in_line,
   // serial output pin, three signals
   output logic      serial_out_line,
   output logic      serial_out_oe,
   input  wire logic serial_out_in,
   // mode visible to the rest of the chip
   output logic      read_mode
);
   typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA} phase_t;

   // synchronisers: first stage feeds only the second
   logic [1:0] sync_sel;
   logic [1:0] sync_clk;
   logic [1:0] sync_din;
   logic       clk_prev;
   logic       sel_prev;
   logic [1:0] next_sync_sel;
   logic [1:0] next_sync_clk;
   logic [1:0] next_sync_din;
   logic       next_clk_prev;
   logic       next_sel_prev;

   // shifter state
   phase_t      phase;
   logic [4:0]  bit_count;
   logic [22:0] shift;
   logic [15:0] out_shift;
   logic        read_bit;
   logic        load_out;
   phase_t      next_phase;
   logic [4:0]  next_bit_count;
   logic [22:0] next_shift;
   logic [15:0] next_out_shift;
   logic        next_read_bit;
   logic        next_load_out;

   logic         sel_low;
   logic         rise;
   logic         fall;
   logic         sel_fall;
   serial_word_t word;
   reg_write_t   wr;
   logic [7:0]   rd_addr;
   logic [15:0]  rd_data;

   // is this the mode register address
   function automatic logic is_mode_addr(input logic [7:0] a);
      return a == READ_MODE_ADDR;
   endfunction

   always_comb
   begin
      next_sync_sel = {sync_sel[0], serial_select_n};
      next_sync_clk = {sync_clk[0], serial_clk};
      next_sync_din = {sync_din[0], serial_in_line};
      next_clk_prev = sync_clk[1];
      next_sel_prev = sync_sel[1];
   end

   // pins idle as select high, clock low
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         sync_sel <= 2'h3;
         sync_clk <= 2'h0;
         sync_din <= 2'h0;
         clk_prev <= 1'b0;
         sel_prev <= 1'b1;
      end
      else
      begin
         sync_sel <= next_sync_sel;
         sync_clk <= next_sync_clk;
         sync_din <= next_sync_din;
         clk_prev <= next_clk_prev;
         sel_prev <= next_sel_prev;
      end
   end

   assign sel_low  = !sync_sel[1];
   assign sel_fall = sel_prev && !sync_sel[1];
   assign rise     = sel_low && sync_clk[1] && !clk_prev; // [R1] [R2]
   assign fall     = sel_low && !sync_clk[1] && clk_prev;

   // completed word: 23 shifted bits plus the one arriving now
   assign word    = {shift, sync_din[1]}; // [R6] [R12]
   assign rd_addr = {shift[6:0], sync_din[1]};

   // shifting, commit, readback load
   always_comb
   begin
      next_phase     = phase;
      next_bit_count = bit_count;
      next_shift     = shift;
      next_out_shift = out_shift;
      next_read_bit  = read_bit;
      next_load_out  = 1'b0;
      wr             = '0;
      if (!sel_low || sel_fall)
      begin
         // a partial word is simply abandoned
         next_phase     = sel_low ? ST_ADDR : ST_IDLE; // [R4]
         next_bit_count = BIT_COUNT_ZERO; // [R5]
      end
      else if (rise)
      begin
         next_shift = {shift[21:0], sync_din[1]}; // [R12]
         if (bit_count == BIT_COUNT_LAST)
         begin
            next_bit_count = BIT_COUNT_ZERO; // [R5]
            next_phase     = ST_ADDR;
            if (is_mode_addr(word.addr))
            begin
               next_read_bit = word.data[READ_MODE_BIT-1]; // [R10]
            end
            // readback mode locks out all other writes
            wr.en   = !read_bit || is_mode_addr(word.addr); // [R3] [R10]
            wr.addr = word.addr;
            wr.data = word.data;
         end
         else
         begin
            next_bit_count = bit_count + 5'h01;
            if (bit_count == 5'(ADDR_BITS - 1))
            begin
               next_phase    = ST_DATA;
               next_load_out = 1'b1; // address complete, fetch
            end
         end
      end
      else if (fall && phase == ST_DATA && bit_count > 5'(ADDR_BITS))
      begin
         // first data bit must still stand at the 9th rise, so skip the fall before it
         next_out_shift = {out_shift[14:0], 1'b0}; // [R12]
      end
      if (load_out)
      begin
         next_out_shift = rd_data; // [R8]
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         phase     <= ST_IDLE;
         bit_count <= BIT_COUNT_ZERO;
         shift     <= '0;
         out_shift <= '0;
         read_bit  <= 1'b0;
         load_out  <= 1'b0;
      end
      else
      begin
         phase     <= next_phase;
         bit_count <= next_bit_count;
         shift     <= next_shift;
         out_shift <= next_out_shift;
         read_bit  <= next_read_bit;
         load_out  <= next_load_out;
      end
   end

   reg_store u_store (
      .clk     (clk),
      .rst_b   (rst_b),
      .wr      (wr),
      .rd_addr (rd_addr),
      .rd_data (rd_data)
   );

   // driver on only in readback mode; bus can be shared
   assign serial_out_oe   = read_bit; // [R11]
   assign serial_out_line = out_shift[15]; // [R8] [R12]
   assign read_mode       = read_bit;

   property p_ignore_when_high;
      @(posedge clk) disable iff (!rst_b) sync_sel[1] |=> !wr.en && bit_count == BIT_COUNT_ZERO;
   endproperty
   a_ignore_when_high: assert property (p_ignore_when_high) // [R1]
      else $error("activity while select high");
   property p_mode_write;
      @(posedge clk) disable iff (!rst_b)
         (wr.en && is_mode_addr(wr.addr)) |=> read_bit == $past(wr.data[READ_MODE_BIT-1]);
   endproperty
   a_mode_write: assert property (p_mode_write) // [R10]
      else $error("readback bit not taken from mode write");
   property p_hold_first;
      @(posedge clk) disable iff (!rst_b)
         (fall && phase == ST_DATA && bit_count == 5'(ADDR_BITS)) |=> out_shift == $past(out_shift);
   endproperty
   a_hold_first: assert property (p_hold_first) // [R12]
      else $error("first readback bit shifted too early");
   property p_oe_mode;
      @(posedge clk) disable iff (!rst_b) serial_out_oe == read_bit;
   endproperty
   a_oe_mode: assert property (p_oe_mode) // [R11]
      else $error("output enable outside readback");
   property p_commit_24;
      @(posedge clk) disable iff (!rst_b) wr.en |-> rise && bit_count == BIT_COUNT_LAST;
   endproperty
   a_commit_24: assert property (p_commit_24) // [R3]
      else $error("commit not on 24th edge");
   property p_lockout;
      @(posedge clk) disable iff (!rst_b) (wr.en && read_bit) |-> is_mode_addr(wr.addr);
   endproperty
   a_lockout: assert property (p_lockout) // [R10]
      else $error("write during readback");
   property p_partial;
      @(posedge clk) disable iff (!rst_b) $rose(sync_sel[1]) |=> bit_count == BIT_COUNT_ZERO;
   endproperty
   a_partial: assert property (p_partial) // [R4]
      else $error("partial word kept");
   property p_count_step;
      @(posedge clk) disable iff (!rst_b)
         (rise && !sel_fall && bit_count != BIT_COUNT_LAST) |=> bit_count == $past(bit_count) + 5'h01;
   endproperty
   a_count_step: assert property (p_count_step) // [R2] [R5]
      else $error("bit count did not step");
   property p_load;
      @(posedge clk) disable iff (!rst_b) load_out |=> out_shift == $past(rd_data);
   endproperty
   a_load: assert property (p_load) // [R8]
      else $error("readback not loaded");
   property p_addr_phase;
      @(posedge clk) disable iff (!rst_b) next_load_out |-> bit_count == 5'h07 && rise;
   endproperty
   a_addr_phase: assert property (p_addr_phase) // [R6] [R12]
      else $error("fetch not after 8 address bits");
   c_write: cover property (@(posedge clk) wr.en && !read_bit);
   c_mode_on: cover property (@(posedge clk) $rose(read_bit));
   c_back_to_back: cover property (@(posedge clk) wr.en ##[1:1000] wr.en);
   c_partial: cover property (@(posedge clk) (bit_count != BIT_COUNT_ZERO) ##1 $rose(sync_sel[1]));
   c_pin_echo: cover property (@(posedge clk) serial_out_oe && (serial_out_in == serial_out_line));
endmodule // serial_register_access_port

// ---- tb/serial_ctrl_model.sv ----
// controller model: frames words onto the serial pins and captures readback
`timescale 1ns/1ps
module serial_ctrl_model
(
   // system clock for pacing
   input  wire logic clk,
   // serial pins
   output logic      serial_select_n,
   output logic      serial_clk,
   output logic      serial_in_line,
   input  wire logic serial_out_wire
);
   // idle levels: select pulled up, clock and data pulled down
   initial
   begin
      serial_select_n = 1'b1;
      serial_clk      = 1'b0;
      serial_in_line  = 1'b0;
   end

   // four system clocks per phase gives a 160 ns link cycle
   task automatic half();
      repeat (4) @(posedge clk);
      #1;
   endtask

   // shift n bits from the top of bits; sel low leaves select high
   task automatic xfer(input logic [71:0] bits, input int n, input logic sel, output logic [15:0] rd);
      rd = 16'h0000;
      half();
      serial_select_n = ~sel;
      for (int i = 0; i < n; i++)
      begin
         serial_clk     = 1'b0;
         serial_in_line = bits[71 - i];
         half();
         serial_clk = 1'b1;
         half();
         // capture at the falling edge, safest at this rate
         if ((i % 24) >= 8)
            rd = {rd[14:0], serial_out_wire};
      end
      serial_clk     = 1'b0;
      serial_in_line = 1'b0;
      half();
      serial_select_n = 1'b1;
      half();
   endtask
endmodule // serial_ctrl_model

// ---- tb/serial_register_access_port_tb_top.sv ----
// testbench for the serial register access port
`timescale 1ns/1ps
module serial_register_access_port_tb_top;
   import serial_access_pkg::*;
   logic        clk;
   logic        rst_b;
   logic        sel_n;
   logic        sclk;
   logic        sdi;
   logic        sdo;
   logic        sdo_oe;
   logic        rmode;
   wire         sdo_wire;
   int          bad_count;
   int          n_compared;
   logic [15:0] rd;

   // readback pin floats unless the port drives it
   assign sdo_wire = sdo_oe ? sdo : 1'bz;

   serial_register_access_port dut_u (.clk(clk), .rst_b(rst_b), .serial_select_n(sel_n), .serial_clk(sclk),
      .serial_in_line(sdi), .serial_out_line(sdo), .serial_out_oe(sdo_oe), .serial_out_in(sdo_wire),
      .read_mode(rmode));
   serial_ctrl_model ctrl_u (.clk(clk), .serial_select_n(sel_n), .serial_clk(sclk), .serial_in_line(sdi),
      .serial_out_wire(sdo_wire));

   // 50 mhz system clock
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp)
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      if (got !== exp)
         bad_count++;
   endtask

   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      ctrl_u.xfer({a, d, 48'h0}, 24, 1'b1, rd);
   endtask

   // enter readback, read one address with a junk data field, leave again
   task automatic rdback(input logic [7:0] a, input logic [15:0] exp);
      wr(READ_MODE_ADDR, 16'h0001);
      chk({15'h0, sdo_oe}, 16'h0001);
      ctrl_u.xfer({a, 16'hffff, 48'h0}, 24, 1'b1, rd);
      chk(rd, exp);
      wr(READ_MODE_ADDR, 16'h0000);
      chk({14'h0, rmode, sdo_oe}, 16'h0000);
   endtask

   task automatic s_basic();
      chk({14'h0, rmode, sdo_oe}, 16'h0000);
      wr(8'h05, 16'ha5c3);
      rdback(8'h05, 16'ha5c3);
   endtask

   // two whole words and a ten-bit tail in one select period
   task automatic s_multi();
      ctrl_u.xfer({8'h10, 16'h1234, 8'h11, 16'hbeef, 8'h10, 16'hffff}, 58, 1'b1, rd);
      rdback(8'h10, 16'h1234);
      rdback(8'h11, 16'hbeef);
   endtask

   // writes other than the mode bit are refused in readback mode
   task automatic s_block();
      wr(READ_MODE_ADDR, 16'h0001);
      wr(8'h10, 16'h0000);
      ctrl_u.xfer({8'h10, 16'h5a5a, 48'h0}, 24, 1'b1, rd);
      chk(rd, 16'h1234);
      wr(READ_MODE_ADDR, 16'h0000);
      rdback(8'h10, 16'h1234);
   endtask

   // clocks with select high must not shift or commit
   task automatic s_idle();
      ctrl_u.xfer({8'h11, 16'h0000, 48'h0}, 24, 1'b0, rd);
      rdback(8'h11, 16'hbeef);
      ctrl_u.xfer({8'h11, 16'h00, 48'h0}, 20, 1'b1, rd);
      wr(8'h11, 16'h0f0f);
      rdback(8'h11, 16'h0f0f);
   endtask

   // watchdog against a hung run
   initial
   begin
      repeat (60000) @(posedge clk);
      bad_count++;
      conclude();
   end

   initial
   begin
      bad_count  = 0;
      n_compared = 0;
      rst_b      = 1'b0;
      repeat (20) @(posedge clk);
      #1 rst_b = 1'b1;
      repeat (4) @(posedge clk);
      s_basic();
      s_multi();
      s_block();
      s_idle();
      conclude();
   end
endmodule // serial_register_access_port_tb_top
